//--- logic/watchdog_unit.sv
// Watchdog timer: 7-bit free-running downcounter, activation flag and reset generator,
// reached over an Avalon-MM slave with waitrequest.
// Assumes CLK is the CPU clock, RST a synchronous system reset, and that the system reset logic
// takes RESET_REQ high as a request to reset the device (and normally drives RST from it).
//
// Behaviour
// - The 7-bit counter decrements continuously whether or not the watchdog is active.
// - When active, a step of the counter from 40h to 3Fh requests a system reset.
// - After any reset the watchdog is disabled, and once active only a reset disables it.
// - The activation bit is set by a software write of one and cleared only by reset.
// - The low seven bits read back the live counter and the whole register reads 7Fh after reset.
// - The six low counter bits written set how many steps remain before the reset.
// - A write with the activation bit set and the counter MSB clear resets at once.
// - While active, a stop instruction produces a reset instead of the low-power state.
// - With the hardware watchdog option the watchdog is always active and the activation bit is unused.
// - With the halt-without-reset option neither stop nor active-halt triggers a watchdog reset.
// - The time to reset spans one prescaler period of spread, set by the unknown prescaler phase.
// - The generated reset phase lasts 256 or 4096 CPU clock cycles.
//
// Register access over Avalon-MM was decided locally.
module watchdog_unit
#(
  parameter int unsigned PRESCALE_CYCLES = watchdog_pkg::PRESCALE_DEFAULT
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Avalon-MM slave
  input wire logic [watchdog_pkg::ADDR_W-1:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [3:0] BYTEENABLE,
  input wire logic [watchdog_pkg::DATA_W-1:0] WRITEDATA,
  output logic [watchdog_pkg::DATA_W-1:0] READDATA,
  output logic WAITREQUEST,
  // Option straps, caught while RST is high
  input wire logic OPT_HW_WATCHDOG,
  input wire logic OPT_HALT_NO_RESET,
  input wire logic OPT_LONG_RESET_PHASE,
  // CPU low-power requests, one-cycle pulses
  input wire logic HALT_EXEC,
  input wire logic ACTIVE_HALT_EXEC,
  // Outputs toward the system
  output logic HALT_ENTER,
  output logic RESET_REQ,
  output logic WATCHDOG_ACTIVE
);
  import watchdog_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [PRE_W-1:0] pre_q;
  logic [PRE_W-1:0] pre_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic active_q;
  logic active_d;
  logic hw_opt_q;
  logic halt_opt_q;
  logic long_opt_q;
  rst_state_t rg_state_q;
  rst_state_t rg_state_d;
  logic [PHASE_W-1:0] phase_q;
  logic [PHASE_W-1:0] phase_d;
  logic wait_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic halt_enter_q;
  logic reset_req_q;
  logic wd_active_q;

  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRESCALE_CYCLES - 1);
  localparam logic [PHASE_W-1:0] PHASE_SHORT_LAST = PHASE_W'(PHASE_SHORT - 1);
  localparam logic [PHASE_W-1:0] PHASE_LONG_LAST = PHASE_W'(PHASE_LONG - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire req = READ | WRITE;
  wire first_cycle = req & wait_q;
  wire commit = req & ~wait_q;
  wire sel_ctrl = (ADDRESS == CTRL_ADDR);
  wire sel_stat = (ADDRESS == STAT_ADDR);
  wire ctrl_wr = commit & WRITE & sel_ctrl & BYTEENABLE[0];
  wire [REG_W-1:0] wr_byte = WRITEDATA[REG_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog decisions
  // Effective activation, including the hardware option
  wire eff_active = active_q | hw_opt_q;
  wire busy = (rg_state_q == RG_BUSY);
  // Prescaler end of period gives one counter step
  wire step = (pre_q == PRE_LAST);
  // Active state seen by a write, counting the activation it may bring
  wire wr_active = eff_active | wr_byte[ACT_BIT];
  // Timeout: counter leaves 40h while active
  wire roll_trig = eff_active & step & (cnt_q == CNT_ROLL) & ~ctrl_wr;
  // Software reset: write while active with the counter MSB clear
  wire sw_trig = ctrl_wr & wr_active & ~wr_byte[MSB_BIT];
  // Stop or active-halt while active, unless the option suppresses it
  wire halt_req = HALT_EXEC | ACTIVE_HALT_EXEC;
  wire halt_trig = halt_req & eff_active & ~halt_opt_q;
  // Any cause starts the reset phase; a timeout in the same cycle as a control write is dropped
  wire trigger = ~busy & (roll_trig | sw_trig | halt_trig);
  wire [PHASE_W-1:0] phase_last = long_opt_q ? PHASE_LONG_LAST : PHASE_SHORT_LAST;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler next value: free-running, writes do not touch it
  always_comb
  begin
    if (pre_q == PRE_LAST)
    begin
      pre_d = '0;
    end
    else
    begin
      pre_d = pre_q + PRE_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter next value: a software load wins over a step
  always_comb
  begin
    cnt_d = cnt_q;
    if (busy)
    begin
      cnt_d = CNT_RESET;
    end
    else if (ctrl_wr)
    begin
      cnt_d = wr_byte[CNT_W-1:0];
    end
    else if (step)
    begin
      cnt_d = cnt_q - CNT_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Activation flag next value: set by software only, cleared by reset phase
  always_comb
  begin
    active_d = active_q;
    if (busy)
    begin
      active_d = 1'b0;
    end
    else if (ctrl_wr & wr_byte[ACT_BIT])
    begin
      active_d = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset generator next state
  always_comb
  begin
    rg_state_d = rg_state_q;
    phase_d = phase_q;
    case (rg_state_q)
      RG_IDLE:
      begin
        if (trigger)
        begin
          rg_state_d = RG_BUSY;
          phase_d = '0;
        end
      end
      RG_BUSY:
      begin
        if (phase_q == phase_last)
        begin
          rg_state_d = RG_IDLE;
          phase_d = '0;
        end
        else
        begin
          phase_d = phase_q + PHASE_W'(1);
        end
      end
      default:
      begin
        rg_state_d = RG_IDLE;
        phase_d = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data for the addressed register; unmapped addresses read zero
  always_comb
  begin
    rdata_d = '0;
    if (sel_ctrl)
    begin
      rdata_d[ACT_BIT] = active_q;
      rdata_d[CNT_W-1:0] = cnt_q;
    end
    else if (sel_stat)
    begin
      rdata_d[ST_ACTIVE] = eff_active;
      rdata_d[ST_HW_OPT] = hw_opt_q;
      rdata_d[ST_HALT_OPT] = halt_opt_q;
      rdata_d[ST_LONG_OPT] = long_opt_q;
      rdata_d[ST_RST_BUSY] = busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Option straps, caught while reset is held
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      hw_opt_q <= OPT_HW_WATCHDOG;
      halt_opt_q <= OPT_HALT_NO_RESET;
      long_opt_q <= OPT_LONG_RESET_PHASE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler cleared by RST, but runs on through the watchdog reset phase as an unknown phase
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      pre_q <= '0;
    end
    else
    begin
      pre_q <= pre_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter and activation flag
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      cnt_q <= CNT_RESET;
      active_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      active_q <= active_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset generator
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      rg_state_q <= RG_IDLE;
      phase_q <= '0;
    end
    else
    begin
      rg_state_q <= rg_state_d;
      phase_q <= phase_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then a single-cycle answer
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      wait_q <= 1'b1;
      rdata_q <= '0;
    end
    else
    begin
      wait_q <= ~first_cycle;
      if (first_cycle & READ)
      begin
        rdata_q <= rdata_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered system outputs; no interrupt exists
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      halt_enter_q <= 1'b0;
      reset_req_q <= 1'b0;
      wd_active_q <= 1'b0;
    end
    else
    begin
      halt_enter_q <= halt_req & ~busy & ~halt_trig;
      reset_req_q <= trigger | (busy & (phase_q != phase_last));
      wd_active_q <= eff_active & ~busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port drive
  assign READDATA = rdata_q;
  assign WAITREQUEST = wait_q;
  assign HALT_ENTER = halt_enter_q;
  assign RESET_REQ = reset_req_q;
  assign WATCHDOG_ACTIVE = wd_active_q;

endmodule : watchdog_unit

//--- logic/wdg_pkg.sv
// Package for the watchdog timer block.
// Assumes a single 50 MHz clock that is also the CPU clock seen by the counter prescaler.
package watchdog_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;

  // Register indices; the byte address is four times the index
  localparam logic [ADDR_W-1:0] CTRL_IDX = 8'h33;
  localparam logic [ADDR_W-1:0] STAT_IDX = 8'h34;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'hcc;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 8'hd0;

  ////////////////////////////////////////////////////////////////////////////
  // Control register layout and values
  localparam int unsigned CNT_W = 7;
  localparam int unsigned ACT_BIT = 7;
  localparam int unsigned MSB_BIT = 6;
  localparam logic [REG_W-1:0] CTRL_RESET = 8'h7f;
  localparam logic [CNT_W-1:0] CNT_RESET = 7'h7f;
  localparam logic [CNT_W-1:0] CNT_ROLL = 7'h40;
  localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;

  // Status register layout
  localparam int unsigned ST_ACTIVE = 0;
  localparam int unsigned ST_HW_OPT = 1;
  localparam int unsigned ST_HALT_OPT = 2;
  localparam int unsigned ST_LONG_OPT = 3;
  localparam int unsigned ST_RST_BUSY = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Timing in CPU clock cycles
  localparam int unsigned PRESCALE_DEFAULT = 16384;
  localparam int unsigned PRE_W = 15;
  localparam int unsigned PHASE_SHORT = 256;
  localparam int unsigned PHASE_LONG = 4096;
  localparam int unsigned PHASE_W = 13;

  // Reset generator states
  typedef enum logic [0:0] {
    RG_IDLE = 1'b0,
    RG_BUSY = 1'b1
  } rst_state_t;

endpackage : watchdog_pkg

//--- tb/tb.sv
// Self-checking bench for the watchdog unit.
// Assumes a shortened prescaler; straps are set at each reset.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import watchdog_pkg::*;
  localparam int P = 16;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rd = 1'b0, wr = 1'b0, hw = 1'b0, hn = 1'b0, lg = 1'b0, hx = 1'b0, ax = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [3:0] be = 4'hf;
  logic [31:0] wd = 32'h0;
  logic [31:0] q, r, r0;
  logic wq, he, wres, act;
  int fail_count = 0;
  int checked = 0;
  int n;
  // Clock
  always #10 clk = ~clk;
  // Device under test
  watchdog_unit #(.PRESCALE_CYCLES(P)) dut_u (.CLK(clk), .RST(rst), .ADDRESS(addr), .READ(rd), .WRITE(wr),
    .BYTEENABLE(be), .WRITEDATA(wd), .READDATA(q), .WAITREQUEST(wq), .OPT_HW_WATCHDOG(hw),
    .OPT_HALT_NO_RESET(hn), .OPT_LONG_RESET_PHASE(lg), .HALT_EXEC(hx), .ACTIVE_HALT_EXEC(ax),
    .HALT_ENTER(he), .RESET_REQ(wres), .WATCHDOG_ACTIVE(act));
  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wd <= {24'h0, d};
    do
      @(posedge clk);
    while (wq !== 1'b0);
    r = q;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task reset(input logic [2:0] o);
    @(posedge clk);
    rst <= 1'b1;
    {hw, hn, lg} <= o;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask : reset
  task halt(input logic a);
    @(posedge clk);
    hx <= !a;
    ax <= a;
    @(posedge clk);
    hx <= 1'b0;
    ax <= 1'b0;
    #1;
  endtask : halt
  task phase(input int len);
    n = 0;
    while (wres === 1'b1 && n < 5000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("phase", n, len);
  endtask : phase
  task complete_run;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  // Register value after reset and an unmapped read
  task scen_reset_values;
    bus(1'b0, CTRL_ADDR, 8'h00);
    chk("ctrl", r, 32'h7f);
    chk("active", act, 1'b0);
    bus(1'b0, 8'h00, 8'h00);
    chk("unmapped", r, 32'h0);
  endtask : scen_reset_values
  // Counter runs while inactive, and a stop is passed on
  task scen_free_count;
    bus(1'b0, CTRL_ADDR, 8'h00);
    r0 = r;
    repeat (3 * P - 3) @(posedge clk);
    bus(1'b0, CTRL_ADDR, 8'h00);
    chk("steps", r0[6:0] - r[6:0], 3);
    halt(1'b0);
    chk("enter", {he, wres}, 2'b10);
  endtask : scen_free_count
  // Masked lane ignored, then activation by a refresh that a zero flag cannot undo
  task scen_activate;
    @(posedge clk);
    be <= 4'he;
    bus(1'b1, CTRL_ADDR, 8'hff);
    be <= 4'hf;
    bus(1'b0, CTRL_ADDR, 8'h00);
    chk("lane", r[7], 1'b0);
    bus(1'b1, CTRL_ADDR, 8'hff);
    bus(1'b1, CTRL_ADDR, 8'h7f);
    bus(1'b0, CTRL_ADDR, 8'h00);
    chk("flag", {r[7], act}, 2'b11);
  endtask : scen_activate
  // Stop while active resets, and the phase clears the flag
  task scen_halt_reset;
    halt(1'b0);
    chk("halt", {he, wres}, 2'b01);
    phase(PHASE_SHORT);
    bus(1'b0, CTRL_ADDR, 8'h00);
    chk("cleared", {r[7], act}, 2'b00);
  endtask : scen_halt_reset
  // Timeout after three steps plus the rollover step
  task scen_timeout;
    bus(1'b1, CTRL_ADDR, 8'hc3);
    n = 0;
    while (wres !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("timeout", n >= 3 * P + 1 && n <= 4 * P + 1, 1'b1);
    phase(PHASE_SHORT);
  endtask : scen_timeout
  // Software reset, with the running phase seen in the status word
  task scen_sw_reset;
    bus(1'b1, CTRL_ADDR, 8'h80);
    #1;
    chk("kill", wres, 1'b1);
    bus(1'b0, STAT_ADDR, 8'h00);
    chk("busy", r, 32'h10);
    // Three cycles of the phase went to the status read
    phase(PHASE_SHORT - 3);
  endtask : scen_sw_reset
  // All straps set: always active, stops let through, long phase
  task scen_options;
    reset(3'b111);
    bus(1'b0, STAT_ADDR, 8'h00);
    chk("status", r, 32'h0f);
    bus(1'b1, CTRL_ADDR, 8'hff);
    halt(1'b0);
    chk("optstop", {he, wres}, 2'b10);
    halt(1'b1);
    chk("optah", {he, wres}, 2'b10);
    bus(1'b1, CTRL_ADDR, 8'h00);
    #1;
    chk("hwkill", wres, 1'b1);
    phase(PHASE_LONG);
  endtask : scen_options
  // Sequence of scenarios
  initial
  begin
    reset(3'b000);
    scen_reset_values();
    scen_free_count();
    scen_activate();
    scen_halt_reset();
    scen_timeout();
    scen_sw_reset();
    scen_options();
    complete_run();
  end
  // Hang guard: the scenarios need about 5000 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    complete_run();
  end
endmodule : tb

//--- tb/watchdog_monitor.sv
// Concurrent checks on the ports of the watchdog unit.
// Assumes the straps stay steady between two resets.
module watchdog_monitor
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Bus
  input wire logic [watchdog_pkg::ADDR_W-1:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [3:0] BYTEENABLE,
  input wire logic [watchdog_pkg::DATA_W-1:0] WRITEDATA,
  input wire logic WAITREQUEST,
  // Straps and halt requests
  input wire logic OPT_HW_WATCHDOG,
  input wire logic OPT_HALT_NO_RESET,
  input wire logic OPT_LONG_RESET_PHASE,
  input wire logic HALT_EXEC,
  input wire logic ACTIVE_HALT_EXEC,
  // Outputs
  input wire logic HALT_ENTER,
  input wire logic RESET_REQ,
  input wire logic WATCHDOG_ACTIVE
);
  import watchdog_pkg::*;
  logic [12:0] ph_q;
  logic [12:0] ph_d;
  logic kill;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////////////////
  // Length of the running reset phase, and a committing write that must reset
  assign ph_d = RESET_REQ ? ph_q + 13'h1 : 13'h0;
  assign kill = WRITE && !WAITREQUEST && ADDRESS == CTRL_ADDR && BYTEENABLE[0] && WRITEDATA[7:6] == 2'b10;
  // Phase counter register
  always_ff @(posedge CLK)
  begin
    ph_q <= RST ? 13'h0 : ph_d;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_bus_answer: assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST ##1 WAITREQUEST)
    else $error("bus answer not one cycle");
  a_phase_len: assert property ($fell(RESET_REQ) |-> ph_q == (OPT_LONG_RESET_PHASE ? 13'h1000 : 13'h100))
    else $error("reset phase length wrong");
  a_sw_reset: assert property (kill && !RESET_REQ |=> RESET_REQ)
    else $error("software reset missing");
  a_halt_reset: assert property (HALT_EXEC && WATCHDOG_ACTIVE && !OPT_HALT_NO_RESET && !RESET_REQ
    |=> RESET_REQ && !HALT_ENTER)
    else $error("halt while active did not reset");
  a_idle_halt: assert property (HALT_EXEC && !WATCHDOG_ACTIVE && !RESET_REQ && !WRITE
    |=> HALT_ENTER && !RESET_REQ)
    else $error("idle halt not passed on");
  a_halt_pass: assert property ((HALT_EXEC || ACTIVE_HALT_EXEC) && OPT_HALT_NO_RESET && !RESET_REQ && !WRITE
    |=> HALT_ENTER)
    else $error("halt with option not passed on");
  a_stay_active: assert property (WATCHDOG_ACTIVE && !RESET_REQ |=> WATCHDOG_ACTIVE || RESET_REQ)
    else $error("watchdog turned off without reset");
  a_quiet_idle: assert property (!WATCHDOG_ACTIVE && !RESET_REQ && !WRITE && !OPT_HW_WATCHDOG |=> !RESET_REQ)
    else $error("reset while inactive");
  a_hw_active: assert property (OPT_HW_WATCHDOG && !RESET_REQ && !$past(RESET_REQ) && !$past(RST)
    |=> WATCHDOG_ACTIVE || RESET_REQ)
    else $error("hardware option not active");
  // Main scenarios
  c_reset: cover property ($rose(RESET_REQ));
  c_enter: cover property (HALT_ENTER);
  c_kill: cover property (kill);
endmodule : watchdog_monitor

bind watchdog_unit watchdog_monitor mon_u (.CLK(CLK), .RST(RST), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
  .BYTEENABLE(BYTEENABLE), .WRITEDATA(WRITEDATA), .WAITREQUEST(WAITREQUEST), .OPT_HW_WATCHDOG(OPT_HW_WATCHDOG),
  .OPT_HALT_NO_RESET(OPT_HALT_NO_RESET), .OPT_LONG_RESET_PHASE(OPT_LONG_RESET_PHASE), .HALT_EXEC(HALT_EXEC),
  .ACTIVE_HALT_EXEC(ACTIVE_HALT_EXEC), .HALT_ENTER(HALT_ENTER), .RESET_REQ(RESET_REQ),
  .WATCHDOG_ACTIVE(WATCHDOG_ACTIVE));
